//--- logic/dds_pkg.sv
// shared constants and carrier types for the dds phase accumulator core
package dds_pkg;
  localparam int ACC_W       = 48;
  localparam int ADDR_W      = 14;
  localparam int SAMPLE_W    = 12;
  localparam int DEPTH       = 16384;
  localparam int FIFO_DEPTH  = 16;
  localparam int MIN_POINTS  = 8;
  localparam int MAX_POINTS  = 16000;
  localparam int BUILTIN_MIN_POINTS = 16000;
  localparam int CLK_MHZ     = 125;
  localparam int SAMPLE_MHZ  = 40;
  localparam logic [7:0] PHASE_NUM = 8'h28;
  localparam logic [7:0] PHASE_DEN = 8'h7d;
  localparam logic [ACC_W-1:0]    ACC_RESET    = 48'h0;
  localparam logic [ACC_W-1:0]    STEP_RESET   = 48'h0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 12'h800;
  localparam logic [SAMPLE_W-1:0] CODE_MIN     = 12'h000;
  localparam logic [SAMPLE_W-1:0] CODE_MAX     = 12'hfff;

  typedef enum logic [2:0] {
    FN_SINE   = 3'b000,
    FN_SQUARE = 3'b001,
    FN_TRI    = 3'b010,
    FN_RAMP   = 3'b011,
    FN_NOISE  = 3'b100,
    FN_USER   = 3'b101
  } func_type;

  typedef enum logic [0:0] {
    FILT_BESSEL   = 1'b0,
    FILT_ELLIPTIC = 1'b1
  } filt_type;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [SAMPLE_W-1:0] data;
  } wave_wr_type;
endpackage

//--- logic/dds_core.sv
// dds core: sample enable, phase accumulator, waveform ram, write fifo, dac output
`timescale 1ns/100ps

module dds_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_r;
  logic [PW:0]      rd_r;
  wire              full  = (wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = in_valid_in && !full;
  wire              pop   = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_r[PW-1:0]];
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_r[PW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

module dds_core
  import dds_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic [ACC_W-1:0]    phase_step_in,
  input  wire logic                phase_step_load_in,
  input  wire dds_pkg::func_type   func_sel_in,
  input  wire logic                wave_wr_valid_in,
  output logic                     wave_wr_ready_out,
  input  wire dds_pkg::wave_wr_type wave_wr_in,
  input  wire logic                wave_wr_hold_in,
  output logic [SAMPLE_W-1:0]      dac_data_out,
  output logic                     dac_strobe_out,
  output dds_pkg::filt_type        filter_sel_out,
  output logic [ADDR_W-1:0]        ram_addr_out
);
  logic [ACC_W-1:0]    phase_step_register_r;
  logic [ACC_W-1:0]    acc_r;
  logic [ACC_W-1:0]    acc_nxt;
  logic [7:0]          frac_r;
  logic [7:0]          frac_nxt;
  logic [8:0]          frac_sum;
  logic                frac_wrap;
  logic                tick_r;
  logic [SAMPLE_W-1:0] wave_ram [DEPTH];
  logic [SAMPLE_W-1:0] sample_r;
  logic [SAMPLE_W-1:0] sample_nxt;
  logic                strobe_r;
  logic                fifo_valid;
  wave_wr_type         fifo_word;
  logic                ram_wr;
  logic [ADDR_W-1:0]   rd_addr;
  logic [SAMPLE_W-1:0] ram_code;
  logic [SAMPLE_W-1:0] square_code;
  logic [SAMPLE_W-1:0] ramp_code;
  logic [SAMPLE_W-1:0] tri_half;
  logic [SAMPLE_W-1:0] tri_code;
  logic                shape_square;
  logic                shape_tri;
  logic                shape_ramp;
  filt_type            filt_nxt;
  filt_type            filt_r;

  // fractional divider gives an average 40 MHz tick from 125 MHz;
  // ticks come 3 or 4 clocks apart, so the dac sees slight jitter
  assign frac_sum  = {1'b0, frac_r} + {1'b0, PHASE_NUM};
  assign frac_wrap = (frac_sum >= {1'b0, PHASE_DEN});
  assign frac_nxt  = frac_wrap ? 8'(frac_sum - {1'b0, PHASE_DEN}) : frac_sum[7:0];

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frac_r <= 8'h00;
    end else begin
      frac_r <= frac_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= frac_wrap;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_step_register_r <= STEP_RESET;
    end else if (phase_step_load_in) begin
      phase_step_register_r <= phase_step_in;
    end
  end

  // the accumulator is never cleared by a load, so the phase stays continuous
  assign acc_nxt = acc_r + phase_step_register_r;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r <= ACC_RESET;
    end else if (tick_r) begin
      acc_r <= acc_nxt;
    end
  end

  assign rd_addr      = acc_r[ACC_W-1 -: ADDR_W];
  assign ram_addr_out = rd_addr;

  // ram writes pause while the read port is busy on a tick, so the fifo can fill
  assign ram_wr = fifo_valid && !tick_r && !wave_wr_hold_in;

  dds_fifo #(
    .WIDTH ($bits(wave_wr_type)),
    .DEPTH (FIFO_DEPTH)
  ) dds_fifo_inst (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (wave_wr_valid_in),
    .in_ready_out  (wave_wr_ready_out),
    .in_data_in    (wave_wr_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (ram_wr),
    .out_data_out  (fifo_word)
  );

  // user data of any code span is accepted; full span is the loader's concern
  always_ff @(posedge core_clk_in) begin
    if (ram_wr) begin
      wave_ram[fifo_word.addr] <= fifo_word.data;
    end
  end

  // built-in shapes are computed from the read address: 16384 points per
  // cycle, each spanning codes 000 to fff; no ram space is spent on them
  assign square_code = rd_addr[ADDR_W-1] ? CODE_MAX : CODE_MIN;
  assign ramp_code   = rd_addr[ADDR_W-1 -: SAMPLE_W];
  assign tri_half    = rd_addr[ADDR_W-2 -: SAMPLE_W];
  assign tri_code    = rd_addr[ADDR_W-1] ? ~tri_half : tri_half;

  assign shape_square = (func_sel_in == FN_SQUARE);
  assign shape_tri    = (func_sel_in == FN_TRI);
  assign shape_ramp   = (func_sel_in == FN_RAMP);

  // sine, noise and user shapes come from the loaded ram, whose length
  // of 8 to 16000 points is the loader's to keep
  assign ram_code   = wave_ram[rd_addr];
  assign sample_nxt = shape_square ? square_code :
                      shape_tri    ? tri_code    :
                      shape_ramp   ? ramp_code   :
                                     ram_code;

  // one register between memory and dac; a repeated address holds the sample
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sample_r <= SAMPLE_RESET;
    end else if (tick_r) begin
      sample_r <= sample_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= tick_r;
    end
  end

  assign dac_data_out   = sample_r;
  assign dac_strobe_out = strobe_r;

  assign filt_nxt = (func_sel_in == FN_SINE) ? FILT_ELLIPTIC : FILT_BESSEL;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt_r <= FILT_ELLIPTIC;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  assign filter_sel_out = filt_r;

endmodule

//--- sim/dds_dac_model.sv
// dac side model: latches each strobed sample as its output level
`timescale 1ns/100ps
module dds_dac_model
  import dds_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                strobe_in,
  input  wire logic [SAMPLE_W-1:0] code_in,
  output logic      [SAMPLE_W-1:0] level_out
);
  always_ff @(posedge core_clk_in) if (strobe_in) level_out <= code_in;
endmodule

//--- sim/dds_core_monitor.sv
// port-level checks of the dds core
`timescale 1ns/100ps
module dds_core_monitor
  import dds_pkg::*;
(
  input wire logic                core_clk_in,
  input wire logic                reset_n_in,
  input wire dds_pkg::func_type   func_sel_in,
  input wire logic [SAMPLE_W-1:0] dac_data_out,
  input wire logic                dac_strobe_out,
  input wire dds_pkg::filt_type   filter_sel_out,
  input wire logic [ADDR_W-1:0]   ram_addr_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_filter_sine: assert property (func_sel_in == FN_SINE |=> filter_sel_out == FILT_ELLIPTIC)
    else $error("sine without elliptic");
  chk_filter_other: assert property (func_sel_in != FN_SINE |=> filter_sel_out == FILT_BESSEL)
    else $error("non-sine without bessel");
  chk_filter_steady: assert property ($stable(func_sel_in) |=> $stable(filter_sel_out))
    else $error("filter moved alone");
  chk_data_on_tick: assert property (!dac_strobe_out |-> $stable(dac_data_out))
    else $error("sample changed off tick");
  chk_addr_on_tick: assert property (!dac_strobe_out |-> $stable(ram_addr_out))
    else $error("address changed off tick");
  chk_strobe_gap: assert property (dac_strobe_out |=> !dac_strobe_out [*2])
    else $error("ticks too close");
  chk_tick_rate: assert property (dac_strobe_out |-> ##[3:4] dac_strobe_out)
    else $error("tick late");
  chk_reset_sample: assert property ($rose(reset_n_in) |-> dac_data_out == SAMPLE_RESET)
    else $error("bad reset sample");
endmodule
bind dds_core dds_core_monitor dds_core_monitor_inst (.core_clk_in, .reset_n_in, .func_sel_in,
  .dac_data_out, .dac_strobe_out, .filter_sel_out, .ram_addr_out);

//--- sim/dds_core_test.sv
// self-checking bench: dds core against a behavioural phase and memory model
`timescale 1ns/100ps
module dds_core_test;
  import dds_pkg::*;
  logic core_clk_in = 0, reset_n_in = 0, ld = 0, vld = 0, hold = 1, rdy, stb;
  logic [ACC_W-1:0] step = '0, acc = '0, r1 = '0, r2 = '0;
  logic [SAMPLE_W-1:0] dac, lvl, mem [DEPTH];
  logic [ADDR_W-1:0] addr;
  func_type fn = FN_SINE, fprev = FN_SINE;
  filt_type filt;
  wave_wr_type wd = '0;
  int miscompares = 0, n_checks = 0, cyc = 0, seed = 67, run = 0;
  dds_core dds_core_inst (.core_clk_in, .reset_n_in, .phase_step_in(step),
    .phase_step_load_in(ld), .func_sel_in(fn), .wave_wr_valid_in(vld),
    .wave_wr_ready_out(rdy), .wave_wr_in(wd), .wave_wr_hold_in(hold),
    .dac_data_out(dac), .dac_strobe_out(stb), .filter_sel_out(filt), .ram_addr_out(addr));
  dds_dac_model dds_dac_model_inst (.core_clk_in, .strobe_in(stb), .code_in(dac),
    .level_out(lvl));
  initial forever #4 core_clk_in = ~core_clk_in;
  task chk(logic [47:0] seen, logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(int a);
    wd.addr = a[ADDR_W-1:0];
    wd.data = 12'($random(seed));
    mem[a] = wd.data;
    vld = 1;
    repeat (40) if (!rdy) @(negedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  function automatic logic [11:0] want(func_type f, logic [13:0] a);
    case (f)
      FN_SQUARE: return a[13] ? 12'hfff : 12'h000;
      FN_TRI:    return a[13] ? ~a[12:1] : a[12:1];
      FN_RAMP:   return a[13:2];
      default:   return mem[a];
    endcase
  endfunction
  // model reads the register one clock late: a load only reaches the tick after it lands
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      print_verdict;
    end
    if (run && stb) begin
      chk(dac, want(fprev, acc[47:34]));
      acc += r2;
      chk(addr, acc[47:34]);
    end
    if (run) chk(filt, fprev == FN_SINE ? FILT_ELLIPTIC : FILT_BESSEL);
    fprev = fn;
    r2 = r1;
    if (ld) r1 = step;
  end
  initial begin
    repeat (12) @(negedge core_clk_in);
    reset_n_in = 1;
    for (int a = 0; a < DEPTH; a++) begin
      if (a == FIFO_DEPTH) begin
        chk(rdy, 0);
        hold = 0;
      end
      wr(a);
    end
    vld = 0;
    repeat (64) @(negedge core_clk_in);
    run = 1;
    for (int i = 0; i < 7; i++) begin
      case (i)
        0: step = 48'h4_0000_0000;
        1: step = 48'h1_0000_0000;
        2: step = 48'hfffc_0000_0000;
        3: step = 48'h0;
        4: step = 48'h3_ffff_ffff;
        default: step = 48'({$random(seed), $random(seed)});
      endcase
      fn = func_type'(3'(i % 6));
      ld = 1;
      @(negedge core_clk_in);
      ld = 0;
      repeat (200) @(negedge core_clk_in);
    end
    print_verdict;
  end
endmodule
